//--- hdl/sdrr_device.sv
// Converter end: sinc5 decimation, ready/data pin framing and sync detection
//
// Overview of operation
// - Sinc5 filter, 64 modulator samples per word
// - Modulator runs at system clock over six
// - Output settles after five conversions, 1920 clocks
// - First ready pulse only for valid data
// - Pin alternates ready phase and data phase
// - Load high, low t2, high t3, data
// - Bits change on falling shift clock edge
// - Host waits after ready phase before clocking
// - Host reads whole word before next ready
// - MSB one keeps pin high after t3
// - No clocks: MSB held until pre-ready
// - Short read: last bit held until pre-ready
// - Over-read: pin low until pre-ready
// - Bit pointer reset at load and pre-ready
// - Shift clock high four cycles triggers sync
// - Falling shift clock releases modulator reset
// - Host holds clock five cycles for multi-sync
// - First ready after sync carries valid data
// - 384-clock cycle: 36 ready, 348 output
// - 24-bit two's complement, MSB first
`timescale 1ns/1ps
module sdrr_device #(
  parameter int WIDTH = 24                  // Result width
) (
  input  wire logic             mclk,       // System clock
  input  wire logic             srst,       // Synchronous reset, active high
  input  wire logic             clk_en,     // Clock enable, freezes state when low
  input  wire logic             mod_bit,    // Modulator output bit, one per modulator clock
  output logic                  mod_rst,    // Modulator held in reset
  output logic                  mod_stb,    // Modulator clock strobe
  output logic [WIDTH-1:0]      result,     // Last loaded result
  sdrr_if.dev                   lnk         // Link to host
);
  typedef enum logic [1:0] {SDRR_RUN, SDRR_SYNC_PULSE, SDRR_SYNC_HOLD} sdrr_st_e;
  localparam int FW = 32;
  // ---------------------------------------------------------------
  // Shift clock synchroniser
  // ---------------------------------------------------------------
  logic sc_m_r, sc_s_r, sc_d_r;
  logic sc_m_nxt, sc_s_nxt, sc_d_nxt;
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [2:0]        div_r, div_nxt;
  logic [8:0]        cyc_r, cyc_nxt;
  logic [2:0]        conv_r, conv_nxt;
  logic [4:0]        high_r, high_nxt;
  logic [8:0]        hcnt_r, hcnt_nxt;
  logic [4:0]        ptr_r, ptr_nxt;
  logic [WIDTH-1:0]  sreg_r, sreg_nxt;
  logic [WIDTH-1:0]  res_r, res_nxt;
  logic              pin_r, pin_nxt;
  logic              mrst_r, mrst_nxt;
  logic              stb_r, stb_nxt;
  logic [FW-1:0]     integ_r [5];
  logic [FW-1:0]     integ_nxt [5];
  logic [FW-1:0]     comb_d_r [5];
  logic [FW-1:0]     comb_d_nxt [5];
  logic [FW-1:0]     comb_v [6];
  sdrr_st_e          st_r, st_nxt;
  logic              sc_fall, mod_tick, word_end;

  assign sc_fall  = ~sc_s_r & sc_d_r;
  assign mod_tick = (div_r == 3'(sdrr_pkg::MOD_DIV - 1));
  assign word_end = (cyc_r == 9'(sdrr_pkg::CYCLE_CLKS - 1));

  // ---------------------------------------------------------------
  // Sinc5 comb stages at word rate
  // ---------------------------------------------------------------
  // five comb differences
  assign comb_v[0] = integ_r[4];
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_comb
      assign comb_v[g+1] = comb_v[g] - comb_d_r[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    sc_m_nxt = lnk.shift_clk;
    sc_s_nxt = sc_m_r;
    sc_d_nxt = sc_s_r;
    div_nxt  = mod_tick ? 3'h0 : div_r + 3'h1;
    cyc_nxt  = word_end ? sdrr_pkg::CNT_RST : cyc_r + 9'h001;
    conv_nxt = conv_r;
    high_nxt = high_r;
    hcnt_nxt = hcnt_r;
    ptr_nxt  = ptr_r;
    sreg_nxt = sreg_r;
    res_nxt  = res_r;
    pin_nxt  = pin_r;
    mrst_nxt = mrst_r;
    st_nxt   = st_r;
    stb_nxt  = mod_tick & ~mrst_r;
    for (int i = 0; i < 5; i++) begin
      integ_nxt[i]  = integ_r[i];
      comb_d_nxt[i] = comb_d_r[i];
    end
    if (mod_tick && !mrst_r) begin
      integ_nxt[0] = integ_r[0] + (mod_bit ? 32'h0000_0001 : 32'hffff_ffff);
      for (int i = 1; i < 5; i++) integ_nxt[i] = integ_r[i] + integ_r[i-1];
    end
    if (!sc_s_r) begin
      high_nxt = 5'h00;
      hcnt_nxt = sdrr_pkg::CNT_RST;
    end else if (hcnt_r == 9'(sdrr_pkg::CYCLE_CLKS - 1)) begin
      hcnt_nxt = sdrr_pkg::CNT_RST;
      if (high_r != 5'h1f) high_nxt = high_r + 5'h01;
    end else begin
      hcnt_nxt = hcnt_r + 9'h001;
    end
    case (st_r)
      SDRR_RUN: begin
        if (cyc_r < 9'(sdrr_pkg::LOAD_CLKS)) begin
          pin_nxt = 1'b1;
          if (cyc_r == 9'h000) begin
            ptr_nxt = 5'h00;
            for (int i = 0; i < 5; i++) comb_d_nxt[i] = comb_v[i];
            // scaled two's complement word, positive end saturated
            if (comb_v[5][WIDTH+7:WIDTH+6] == 2'b01) sreg_nxt = {1'b0, {(WIDTH-1){1'b1}}};
            else sreg_nxt = comb_v[5][WIDTH+6:7];
            // count settling conversions, one extra for the unaligned start
            if (conv_r != 3'(sdrr_pkg::SETTLE_CONV + 1)) conv_nxt = conv_r + 3'h1;
          end
        end else if (cyc_r < 9'(sdrr_pkg::LOAD_CLKS + sdrr_pkg::LOW_CLKS)) begin
          pin_nxt = (conv_r != 3'(sdrr_pkg::SETTLE_CONV + 1));
          if (conv_r == 3'(sdrr_pkg::SETTLE_CONV + 1)) res_nxt = sreg_r;
        end else if (cyc_r < 9'(sdrr_pkg::READY_CLKS - 18)) begin
          pin_nxt = 1'b1;
        end else if (cyc_r == 9'(sdrr_pkg::CYCLE_CLKS - sdrr_pkg::PRE_READY_CLKS)) begin
          pin_nxt = 1'b1;
          ptr_nxt = 5'h00;
        end else if (cyc_r > 9'(sdrr_pkg::CYCLE_CLKS - sdrr_pkg::PRE_READY_CLKS)) begin
          pin_nxt = 1'b1;
        end else begin
          if (cyc_r == 9'(sdrr_pkg::LOAD_CLKS + sdrr_pkg::LOW_CLKS + sdrr_pkg::HIGH_CLKS))
            pin_nxt = sreg_r[WIDTH-1];
          if (sc_fall && cyc_r >= 9'(sdrr_pkg::READY_CLKS)) begin
            if (ptr_r < 5'(WIDTH - 1)) pin_nxt = sreg_r[WIDTH-2-ptr_r];
            else pin_nxt = 1'b0;
            if (ptr_r != 5'h1f) ptr_nxt = ptr_r + 5'h01;
          end
        end
        if (high_r == 5'(sdrr_pkg::SYNC_CYCLES)) begin
          st_nxt   = SDRR_SYNC_PULSE;
          pin_nxt  = 1'b0;
          mrst_nxt = 1'b1;
        end
      end
      SDRR_SYNC_PULSE: begin
        pin_nxt = 1'b1;
        st_nxt  = SDRR_SYNC_HOLD;
      end
      SDRR_SYNC_HOLD: begin
        pin_nxt = 1'b1;
        if (sc_fall) begin
          st_nxt   = SDRR_RUN;
          mrst_nxt = 1'b0;
          conv_nxt = 3'h0;
          cyc_nxt  = 9'h001;
          div_nxt  = 3'h0;
          for (int i = 0; i < 5; i++) begin
            integ_nxt[i]  = '0;
            comb_d_nxt[i] = '0;
          end
        end
      end
      default: st_nxt = SDRR_RUN;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      sc_m_r <= 1'b0;
      sc_s_r <= 1'b0;
      sc_d_r <= 1'b0;
      div_r  <= 3'h0;
      cyc_r  <= sdrr_pkg::CNT_RST;
      conv_r <= 3'h0;
      high_r <= 5'h00;
      hcnt_r <= sdrr_pkg::CNT_RST;
      ptr_r  <= 5'h00;
      sreg_r <= '0;
      res_r  <= '0;
      pin_r  <= 1'b1;
      mrst_r <= 1'b0;
      stb_r  <= 1'b0;
      st_r   <= SDRR_RUN;
      for (int i = 0; i < 5; i++) begin
        integ_r[i]  <= '0;
        comb_d_r[i] <= '0;
      end
    end else if (clk_en) begin
      sc_m_r <= sc_m_nxt;
      sc_s_r <= sc_s_nxt;
      sc_d_r <= sc_d_nxt;
      div_r  <= div_nxt;
      cyc_r  <= cyc_nxt;
      conv_r <= conv_nxt;
      high_r <= high_nxt;
      hcnt_r <= hcnt_nxt;
      ptr_r  <= ptr_nxt;
      sreg_r <= sreg_nxt;
      res_r  <= res_nxt;
      pin_r  <= pin_nxt;
      mrst_r <= mrst_nxt;
      stb_r  <= stb_nxt;
      st_r   <= st_nxt;
      for (int i = 0; i < 5; i++) begin
        integ_r[i]  <= integ_nxt[i];
        comb_d_r[i] <= comb_d_nxt[i];
      end
    end
  end

  assign lnk.ready_data_pin = pin_r;
  assign mod_rst            = mrst_r;
  assign mod_stb            = stb_r;
  assign result             = res_r;
endmodule

//--- hdl/sdrr_pkg.sv
// Shared constants for the sigma-delta result readout link
package sdrr_pkg;
  // ---------------------------------------------------------------
  // Timing in system clocks
  // ---------------------------------------------------------------
  localparam int MOD_DIV        = 6;
  localparam int OSR            = 64;
  localparam int CYCLE_CLKS     = MOD_DIV * OSR;
  localparam int LOAD_CLKS      = 6;
  localparam int LOW_CLKS       = 6;
  localparam int HIGH_CLKS      = 6;
  localparam int READY_CLKS     = LOAD_CLKS + LOW_CLKS + HIGH_CLKS + 18;
  localparam int PRE_READY_CLKS = 24;
  localparam int OUT_CLKS       = CYCLE_CLKS - READY_CLKS;
  localparam int SETTLE_CONV    = 5;
  localparam int SETTLE_CLKS    = SETTLE_CONV * OSR * MOD_DIV;
  localparam int SYNC_CYCLES    = 4;
  localparam int WORD_BITS      = 24;
  localparam int HOST_HALF_CLKS = 4;
  localparam int HOST_WAIT_CLKS = 2;
  localparam int HOST_SYNC_CONV = 5;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [8:0] CNT_RST = 9'h000;
endpackage

//--- hdl/sdrr_if.sv
// Interface joining the converter end and the host end
`timescale 1ns/1ps
interface sdrr_if;
  logic shift_clk;        // Host shift clock, idles low
  logic ready_data_pin;   // Multiplexed ready / serial data pin
  modport dev  (input shift_clk, output ready_data_pin);
  modport host (output shift_clk, input ready_data_pin);
endinterface

//--- hdl/sdrr_host.sv
// Host end: waits for the ready pulse, clocks out the word, requests sync
`timescale 1ns/1ps
module sdrr_host #(
  parameter int WIDTH = 24                  // Result width
) (
  input  wire logic             mclk,       // System clock
  input  wire logic             srst,       // Synchronous reset, active high
  input  wire logic             clk_en,     // Clock enable, freezes state when low
  input  wire logic             sync_req,   // Pulse: request converter sync
  output logic [WIDTH-1:0]      data,       // Last received word
  output logic                  data_vld,   // One-cycle pulse with new word
  output logic                  busy,       // Sync in progress
  sdrr_if.host                  lnk         // Link to converter
);
  typedef enum logic [2:0] {SDRH_IDLE, SDRH_WAIT, SDRH_HI, SDRH_LO, SDRH_SYNC} sdrh_st_e;
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic             pm_r, ps_r, pd_r;
  logic             sck_r, sck_nxt;
  logic [11:0]      cnt_r, cnt_nxt;
  logic [4:0]       bits_r, bits_nxt;
  logic [WIDTH-1:0] sh_r, sh_nxt, dat_r, dat_nxt;
  logic             vld_r, vld_nxt, busy_r, busy_nxt;
  sdrh_st_e         st_r, st_nxt;

  always_comb begin
    sck_nxt  = sck_r;
    cnt_nxt  = cnt_r + 12'h001;
    bits_nxt = bits_r;
    sh_nxt   = sh_r;
    dat_nxt  = dat_r;
    vld_nxt  = 1'b0;
    busy_nxt = busy_r;
    st_nxt   = st_r;
    case (st_r)
      SDRH_IDLE: begin
        // Length of the current low run on the pin
        cnt_nxt = ps_r ? 12'h000 : cnt_r + 12'h001;
        if (sync_req) begin
          st_nxt   = SDRH_SYNC;
          sck_nxt  = 1'b1;
          busy_nxt = 1'b1;
          cnt_nxt  = 12'h000;
        // Rise after a low run of the ready pulse length ends the strobe
        end else if (ps_r && !pd_r && cnt_r == 12'(sdrr_pkg::LOW_CLKS)) begin
          st_nxt = SDRH_WAIT;
        end
      end
      SDRH_WAIT: begin
        // wait past end of ready phase
        if (cnt_r == 12'(sdrr_pkg::HIGH_CLKS + 18 + sdrr_pkg::HOST_WAIT_CLKS)) begin
          st_nxt   = SDRH_HI;
          sck_nxt  = 1'b1;
          cnt_nxt  = 12'h000;
          bits_nxt = 5'h00;
        end
      end
      SDRH_HI: begin
        // capture late in the high half, past the synchroniser delay
        if (cnt_r == 12'(sdrr_pkg::HOST_HALF_CLKS - 1)) begin
          sh_nxt   = {sh_r[WIDTH-2:0], ps_r};
          sck_nxt  = 1'b0;
          cnt_nxt  = 12'h000;
          bits_nxt = bits_r + 5'h01;
          st_nxt   = SDRH_LO;
        end
      end
      SDRH_LO: begin
        if (cnt_r == 12'(sdrr_pkg::HOST_HALF_CLKS - 1)) begin
          cnt_nxt = 12'h000;
          if (bits_r == 5'(WIDTH)) begin
            st_nxt  = SDRH_IDLE;
            dat_nxt = sh_r;
            vld_nxt = 1'b1;
          end else begin
            st_nxt  = SDRH_HI;
            sck_nxt = 1'b1;
          end
        end
      end
      SDRH_SYNC: begin
        if (cnt_r == 12'(sdrr_pkg::HOST_SYNC_CONV * sdrr_pkg::CYCLE_CLKS / 2 - 1)) begin
          cnt_nxt = 12'h000;
          if (bits_r == 5'h01) begin
            sck_nxt  = 1'b0;
            busy_nxt = 1'b0;
            st_nxt   = SDRH_IDLE;
          end
          bits_nxt = 5'h01;
        end
      end
      default: st_nxt = SDRH_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pm_r   <= 1'b1;
      ps_r   <= 1'b1;
      pd_r   <= 1'b1;
      sck_r  <= 1'b0;
      cnt_r  <= 12'h000;
      bits_r <= 5'h00;
      sh_r   <= '0;
      dat_r  <= '0;
      vld_r  <= 1'b0;
      busy_r <= 1'b0;
      st_r   <= SDRH_IDLE;
    end else if (clk_en) begin
      pm_r   <= lnk.ready_data_pin;
      ps_r   <= pm_r;
      pd_r   <= ps_r;
      sck_r  <= sck_nxt;
      cnt_r  <= cnt_nxt;
      bits_r <= bits_nxt;
      sh_r   <= sh_nxt;
      dat_r  <= dat_nxt;
      vld_r  <= vld_nxt;
      busy_r <= busy_nxt;
      st_r   <= st_nxt;
    end
  end

  assign lnk.shift_clk = sck_r;
  assign data          = dat_r;
  assign data_vld      = vld_r;
  assign busy          = busy_r;
endmodule

//--- verification/sdrr_checker.sv
// Concurrent checks on the ready/data link between converter and host
`timescale 1ns/1ps
module sdrr_checker (
  input wire logic mclk,           // System clock
  input wire logic srst,           // Synchronous reset, active high
  input wire logic shift_clk,      // Host shift clock
  input wire logic ready_data_pin  // Ready / data pin
);
  // --------------------------------------------------------------
  // Frame position since reset and length of shift clock high hold
  // --------------------------------------------------------------
  logic [8:0]  cyc_r;
  logic [2:0]  conv_r;
  logic [11:0] hold_r;
  logic        synced_r;
  wire logic   framed = !synced_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      cyc_r    <= 9'h000;
      conv_r   <= 3'h0;
      hold_r   <= 12'h000;
      synced_r <= 1'b0;
    end else begin
      cyc_r    <= (cyc_r == 9'h17f) ? 9'h000 : cyc_r + 9'h001;
      conv_r   <= (cyc_r == 9'h17f && conv_r != 3'h7) ? conv_r + 3'h1 : conv_r;
      hold_r   <= shift_clk ? hold_r + {11'h000, ~&hold_r} : 12'h000;
      synced_r <= synced_r | (hold_r > 12'h3e8);
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  a_load_high: assert property (framed && cyc_r inside {[1:4]} |-> ready_data_pin)
    else $error("pin low during result load");
  a_gap_high: assert property (framed && cyc_r inside {[13:16]} |-> ready_data_pin)
    else $error("pin low before data output");
  a_pre_ready: assert property (framed && cyc_r inside {[362:382]} |-> ready_data_pin)
    else $error("pin low in pre-ready interval");
  a_early_quiet: assert property (framed && conv_r < 3'h4 && cyc_r inside {[1:16]}
    |-> ready_data_pin)
    else $error("ready pulse before filter settled");
  a_low_pulse: assert property (framed && $fell(ready_data_pin) && cyc_r inside {[5:9]}
    |-> (!ready_data_pin)[*6] ##1 ready_data_pin[*6])
    else $error("ready low or high interval wrong length");
  a_bit_timing: assert property (framed && $changed(ready_data_pin) && cyc_r inside {[21:358]}
    |-> !$past(shift_clk, 3) && ($past(shift_clk, 5) || $past(shift_clk, 6)))
    else $error("data bit changed without shift clock fall");
  a_sync_pulse: assert property ($fell(ready_data_pin) && hold_r > 12'h5dc |=> ready_data_pin)
    else $error("sync pulse longer than one clock");
  a_sync_hold: assert property (hold_r > 12'h64a && shift_clk |-> ready_data_pin)
    else $error("pin not held high during sync");
  a_sync_release: assert property ($fell(shift_clk) && hold_r > 12'h640 |-> ready_data_pin[*8])
    else $error("pin not high after sync release");
endmodule

//--- verification/sdrr_tb.sv
// Bench: converter and host joined, plus a second converter clocked by the bench
`timescale 1ns/1ps
module sdrr_tb;
  logic        mclk;
  logic        srst;
  logic        en;
  logic        mod_bit;
  logic        sync_req;
  logic        rnd_on;
  logic        per_on;
  logic        mod_rst;
  logic        mod_stb;
  logic        busy;
  logic        data_vld;
  logic [23:0] data;
  logic [23:0] wire_word;
  logic [23:0] last_word;
  logic [23:0] w_hi;
  logic [23:0] w_lo;
  logic [31:0] seed;
  int          mismatches;
  int          check_count;
  int          vld_cnt;
  int          tick;
  int          last_tick;

  sdrr_if lnk_a ();
  sdrr_if lnk_b ();
  sdrr_device u_sdrr_device (.mclk(mclk), .srst(srst), .clk_en(en), .mod_bit(mod_bit),
    .mod_rst(mod_rst), .mod_stb(mod_stb), .result(), .lnk(lnk_a));
  sdrr_device u_sdrr_device_b (.mclk(mclk), .srst(srst), .clk_en(en), .mod_bit(mod_bit),
    .mod_rst(), .mod_stb(), .result(), .lnk(lnk_b));
  sdrr_host u_sdrr_host (.mclk(mclk), .srst(srst), .clk_en(en), .sync_req(sync_req),
    .data(data), .data_vld(data_vld), .busy(busy), .lnk(lnk_a));
  sdrr_checker u_sdrr_checker (.mclk(mclk), .srst(srst), .shift_clk(lnk_a.shift_clk),
    .ready_data_pin(lnk_a.ready_data_pin));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] w, input logic b);
    return {w[22:0], b};
  endfunction

  task automatic check_word(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wait_words(input int n);
    int target;
    int i;
    target = vld_cnt + n;
    i = 0;
    while (vld_cnt < target && i < 400 * (n + 8)) begin
      @(posedge mclk);
      i++;
    end
    #1;
    check_word("words", 24'(target), 24'(vld_cnt));
  endtask

  // Bench-driven read of the second converter with n shift clocks
  task automatic read_b(input int n);
    int i;
    int run;
    logic first;
    logic held;
    logic [23:0] w;
    i = 0;
    run = 0;
    while (!(run > 27 && lnk_b.ready_data_pin === 1'b0) && i < 1200) begin
      run = (lnk_b.ready_data_pin === 1'b1) ? run + 1 : 0;
      @(posedge mclk);
      #1;
      i++;
    end
    repeat (32) @(posedge mclk);
    #1;
    first = lnk_b.ready_data_pin;
    for (int k = 0; k < n; k++) begin
      lnk_b.shift_clk = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      w = shift_in(w, lnk_b.ready_data_pin);
      lnk_b.shift_clk = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
    end
    repeat (10) @(posedge mclk);
    #1;
    held = lnk_b.ready_data_pin;
    repeat (300 - 8 * n) @(posedge mclk);
    #1;
    if (n == 24) check_word("read_b", w_lo, w);
    else if (n > 24) check_bit("over_read", 1'b0, lnk_b.ready_data_pin);
    else if (n > 0) check_bit("short_read", held, lnk_b.ready_data_pin);
    else begin
      check_bit("msb_first", w_lo[23], first);
      check_bit("no_clock", first, lnk_b.ready_data_pin);
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (rnd_on) begin
      seed <= xorshift(seed);
      mod_bit <= #1 seed[0];
    end
  end

  always @(negedge lnk_a.shift_clk) wire_word <= shift_in(wire_word, lnk_a.ready_data_pin);

  always @(posedge mclk) begin
    tick <= tick + 1;
    if (data_vld === 1'b1) begin
      vld_cnt <= vld_cnt + 1;
      last_word <= data;
      last_tick <= tick;
      check_word("word", wire_word, data);
      if (per_on) check_word("period", 24'h000180, 24'(tick - last_tick));
    end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    int i;
    int c;
    srst = 1'b1;
    en = 1'b1;
    mod_bit = 1'b0;
    sync_req = 1'b0;
    rnd_on = 1'b0;
    per_on = 1'b0;
    seed = 32'hd07d92d6;
    mismatches = 0;
    check_count = 0;
    vld_cnt = 0;
    tick = 0;
    last_tick = 0;
    lnk_b.shift_clk = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    srst = 1'b0;
    rnd_on = 1'b1;
    wait_words(2);
    per_on = 1'b1;
    c = 0;
    repeat (384) begin
      @(posedge mclk);
      if (mod_stb === 1'b1) c++;
    end
    check_word("mod_stb", 24'h000040, 24'(c));
    wait_words(3);
    per_on = 1'b0;
    rnd_on = 1'b0;
    @(posedge mclk);
    #1;
    mod_bit = 1'b1;
    wait_words(7);
    w_hi = last_word;
    wait_words(1);
    check_word("settled_hi", w_hi, last_word);
    mod_bit = 1'b0;
    wait_words(7);
    w_lo = last_word;
    wait_words(1);
    check_word("settled_lo", w_lo, last_word);
    check_bit("order", 1'b1, $signed(w_hi) > $signed(w_lo));
    sync_req = 1'b1;
    @(posedge mclk);
    #1;
    sync_req = 1'b0;
    i = 0;
    while (mod_rst !== 1'b1 && i < 2500) begin
      @(posedge mclk);
      i++;
    end
    check_bit("sync_hold", 1'b1, mod_rst);
    while (mod_rst !== 1'b0 && i < 5000) begin
      @(posedge mclk);
      i++;
    end
    check_bit("release", 1'b0, lnk_a.shift_clk);
    check_bit("hold_len", 1'b1, i > 1919);
    wait_words(1);
    check_word("after_sync", w_lo, last_word);
    read_b(30);
    read_b(24);
    read_b(10);
    read_b(0);
    finish_test();
  end

  // Watchdog sized well above the expected run length
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    finish_test();
  end
endmodule
